// [rtl/emrm_pkg.sv]
// package: register map, command fields and carrier types of the meter register front end
package emrm_pkg;

  // ---------------------------------------------
  // command byte fields
  // ---------------------------------------------
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_ADDR_W = 6;
  localparam int CMD_RSVD_BIT = 6;
  localparam int CMD_WR_BIT = 7;

  // ---------------------------------------------
  // register addresses
  // ---------------------------------------------
  localparam logic [5:0] ADDR_RSVD = 6'h00;
  localparam logic [5:0] ADDR_ACT = 6'h01;
  localparam logic [5:0] ADDR_ACT_RC = 6'h02;
  localparam logic [5:0] ADDR_LACT = 6'h03;
  localparam logic [5:0] ADDR_APP = 6'h04;
  localparam logic [5:0] ADDR_APP_RC = 6'h05;
  localparam logic [5:0] ADDR_LAPP = 6'h06;
  localparam logic [5:0] ADDR_PERIOD = 6'h07;
  localparam logic [5:0] ADDR_TEMP = 6'h08;
  localparam logic [5:0] ADDR_WAVE = 6'h09;
  localparam logic [5:0] ADDR_OPCFG = 6'h0a;

  // ---------------------------------------------
  // widths and reset values
  // ---------------------------------------------
  localparam int ACC_W = 24;
  localparam int PERIOD_W = 15;
  localparam int TEMP_W = 8;
  localparam int WAVE_W = 24;
  localparam int OPCFG_W = 8;
  localparam int NUM_INPUTS = 6;
  localparam logic [7:0] OPCFG_RST = 8'h04;
  localparam logic [23:0] DATA_RST = 24'h000000;

  // ---------------------------------------------
  // formula, measure and sample select fields
  // ---------------------------------------------
  localparam int FORM_CONT_LSB = 3;
  localparam int FORM_ABS_BIT = 6;
  localparam int FORM_NEGB_BIT = 7;
  localparam int FORM_LINE_LSB = 0;
  localparam int MEAS_PH_LSB = 0;
  localparam int MEAS_EN_LSB = 4;
  localparam int WAVE_SRC_LSB = 0;

  // ---------------------------------------------
  // carrier types
  // ---------------------------------------------
  typedef struct packed {
    logic vld;
    logic [7:0] data;
  } emrm_byte_t;

  typedef enum logic [1:0] {ST_CMD, ST_WR, ST_RD} emrm_state_t;

  // bytes in the data phase for a register, msb byte first
  function automatic logic [1:0] emrm_nbytes(input logic [5:0] addr);
    logic [1:0] n;
    n = 2'h3;
    if (addr == ADDR_PERIOD) begin
      n = 2'h2;
    end else if (addr == ADDR_TEMP || addr == ADDR_OPCFG || addr == ADDR_RSVD || addr > ADDR_OPCFG) begin
      n = 2'h1;
    end
    return n;
  endfunction

endpackage

// [rtl/emrm_pwr_sum.sv]
// module: combines three phase powers into one term by a formula select
`timescale 1ns/1ns
`default_nettype none
module emrm_pwr_sum #(
  parameter int PW = 16
) (
  input wire logic [2:0][PW-1:0] i_ph,
  input wire logic [2:0] i_en,
  input wire logic i_abs,
  input wire logic i_neg_b,
  output logic signed [PW+1:0] o_sum
);
  // ---------------------------------------------
  // per phase term
  // ---------------------------------------------
  logic [2:0][PW+1:0] term;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      wire logic signed [PW+1:0] ext = {{2{i_ph[g][PW-1]}}, i_ph[g]};
      wire logic neg = (i_abs && ext[PW+1]) || (g == 1 && i_neg_b);
      // extended first so the most negative input negates cleanly
      assign term[g] = !i_en[g] ? '0 : (neg ? -ext : ext);
    end
  endgenerate

  // three terms of pw+2 bits cannot overflow pw+2 signed
  assign o_sum = signed'(term[0]) + signed'(term[1]) + signed'(term[2]);

endmodule
`default_nettype wire

// [rtl/emrm_accum.sv]
// module: wrapping energy accumulator with a clear that never drops a same-cycle add
`timescale 1ns/1ns
`default_nettype none
module emrm_accum #(
  parameter int W = 24,
  parameter int IW = 18
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_add,
  input wire logic signed [IW-1:0] i_val,
  input wire logic i_clr,
  output logic [W-1:0] o_acc
);
  logic [W-1:0] acc_q;
  logic [W-1:0] acc_d;
  logic [W-1:0] inc;

  assign inc = i_add ? {{(W-IW){i_val[IW-1]}}, i_val} : '0;
  // clear takes the old total away but keeps this cycle's add
  assign acc_d = (i_clr ? '0 : acc_q) + inc;
  assign o_acc = acc_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

endmodule
`default_nettype wire

// [rtl/emrm_regmap.sv]
// module: command decode, register map and read snapshot of the meter front end
`timescale 1ns/1ns
`default_nettype none
module emrm_regmap import emrm_pkg::*; #(
  parameter int PW = 16
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire emrm_byte_t I_RX,
  input wire logic I_TX_TAKE,
  input wire logic I_ABORT,
  input wire logic I_PWR_STB,
  input wire logic [2:0][PW-1:0] I_ACT_PWR,
  input wire logic [2:0][PW-1:0] I_APP_PWR,
  input wire logic I_HALF_CYC,
  input wire logic [15:0] I_HALF_CYCLE_COUNT,
  input wire logic [7:0] I_ACTIVE_FORMULA_SELECT,
  input wire logic [7:0] I_APPARENT_FORMULA_SELECT,
  input wire logic [7:0] I_MEASURE_CHANNEL_SELECT,
  input wire logic [7:0] I_SAMPLE_SOURCE_SELECT,
  input wire logic I_PERIOD_STB,
  input wire logic [2:0][PERIOD_W-1:0] I_PERIOD,
  input wire logic I_TEMP_STB,
  input wire logic [TEMP_W-1:0] I_TEMP,
  input wire logic I_WAVE_STB,
  input wire logic [NUM_INPUTS-1:0][WAVE_W-1:0] I_WAVE,
  output logic [7:0] O_RD_BYTE,
  output logic O_RD_VLD,
  output logic [7:0] O_OPERATING_CONFIG
);
  // ---------------------------------------------
  // command decode
  // ---------------------------------------------
  emrm_state_t state_q;
  emrm_state_t state_d;
  logic [5:0] addr_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [23:0] shift_q;
  logic rd_vld_q;
  logic [7:0] cfg_q;

  wire logic [5:0] cmd_addr = I_RX.data[CMD_ADDR_LSB +: CMD_ADDR_W];
  wire logic cmd_wr = I_RX.data[CMD_WR_BIT];
  // bit 6 is not decoded at all, so a stray one cannot change the access
  wire logic cmd_take = state_q == ST_CMD && I_RX.vld;
  wire logic rd_start = cmd_take && !cmd_wr;
  wire logic wr_byte = state_q == ST_WR && I_RX.vld;
  wire logic wr_last = wr_byte && cnt_q == 2'h1;
  wire logic rd_take = state_q == ST_RD && I_TX_TAKE;
  wire logic rd_last = rd_take && cnt_q == 2'h1;
  // only the last, least significant byte can land in the 8-bit config
  wire logic cfg_wr = wr_last && addr_q == ADDR_OPCFG;
  wire logic clr_act = rd_start && !I_ABORT && cmd_addr == ADDR_ACT_RC;
  wire logic clr_app = rd_start && !I_ABORT && cmd_addr == ADDR_APP_RC;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (I_ABORT) begin
      state_d = ST_CMD;
    end else begin
      case (state_q)
        ST_CMD: begin
          if (cmd_take) begin
            state_d = cmd_wr ? ST_WR : ST_RD;
            cnt_d = emrm_nbytes(cmd_addr);
          end
        end
        ST_WR: begin
          if (wr_byte) begin
            cnt_d = cnt_q - 2'h1;
            state_d = wr_last ? ST_CMD : ST_WR;
          end
        end
        ST_RD: begin
          if (rd_take) begin
            cnt_d = cnt_q - 2'h1;
            state_d = rd_last ? ST_CMD : ST_RD;
          end
        end
        default: begin
          state_d = ST_CMD;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // energy datapath
  // ---------------------------------------------
  logic signed [PW+1:0] act_cont;
  logic signed [PW+1:0] act_line;
  logic signed [PW+1:0] app_cont;
  logic signed [PW+1:0] app_line;
  logic [ACC_W-1:0] act_acc;
  logic [ACC_W-1:0] app_acc;
  logic [ACC_W-1:0] lact_acc;
  logic [ACC_W-1:0] lapp_acc;
  logic [ACC_W-1:0] lact_q;
  logic [ACC_W-1:0] lapp_q;
  logic [15:0] hc_cnt_q;

  wire logic [16:0] hc_next = {1'b0, hc_cnt_q} + 17'h00001;
  wire logic line_done = I_HALF_CYC && hc_next >= {1'b0, I_HALF_CYCLE_COUNT};

  emrm_pwr_sum #(.PW(PW)) u_act_cont (
    .i_ph(I_ACT_PWR),
    .i_en(I_ACTIVE_FORMULA_SELECT[FORM_CONT_LSB +: 3]),
    .i_abs(I_ACTIVE_FORMULA_SELECT[FORM_ABS_BIT]),
    .i_neg_b(I_ACTIVE_FORMULA_SELECT[FORM_NEGB_BIT]),
    .o_sum(act_cont)
  );
  emrm_pwr_sum #(.PW(PW)) u_act_line (
    .i_ph(I_ACT_PWR),
    .i_en(I_ACTIVE_FORMULA_SELECT[FORM_LINE_LSB +: 3]),
    .i_abs(1'b0),
    .i_neg_b(1'b0),
    .o_sum(act_line)
  );
  emrm_pwr_sum #(.PW(PW)) u_app_cont (
    .i_ph(I_APP_PWR),
    .i_en(I_APPARENT_FORMULA_SELECT[FORM_CONT_LSB +: 3]),
    .i_abs(I_APPARENT_FORMULA_SELECT[FORM_ABS_BIT]),
    .i_neg_b(I_APPARENT_FORMULA_SELECT[FORM_NEGB_BIT]),
    .o_sum(app_cont)
  );
  emrm_pwr_sum #(.PW(PW)) u_app_line (
    .i_ph(I_APP_PWR),
    .i_en(I_APPARENT_FORMULA_SELECT[FORM_LINE_LSB +: 3]),
    .i_abs(1'b0),
    .i_neg_b(1'b0),
    .o_sum(app_line)
  );

  emrm_accum #(.W(ACC_W), .IW(PW+2)) u_act_acc (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_add(I_PWR_STB),
    .i_val(act_cont),
    .i_clr(clr_act),
    .o_acc(act_acc)
  );
  emrm_accum #(.W(ACC_W), .IW(PW+2)) u_app_acc (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_add(I_PWR_STB),
    .i_val(app_cont),
    .i_clr(clr_app),
    .o_acc(app_acc)
  );
  emrm_accum #(.W(ACC_W), .IW(PW+2)) u_lact_acc (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_add(I_PWR_STB),
    .i_val(act_line),
    .i_clr(line_done),
    .o_acc(lact_acc)
  );
  emrm_accum #(.W(ACC_W), .IW(PW+2)) u_lapp_acc (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_add(I_PWR_STB),
    .i_val(app_line),
    .i_clr(line_done),
    .o_acc(lapp_acc)
  );

  // ---------------------------------------------
  // period, temperature and sample capture
  // ---------------------------------------------
  logic [PERIOD_W-1:0] period_q;
  logic [TEMP_W-1:0] temp_q;
  logic [WAVE_W-1:0] wave_q;

  wire logic [1:0] per_ph = I_MEASURE_CHANNEL_SELECT[MEAS_PH_LSB +: 2];
  wire logic [2:0] per_en = I_MEASURE_CHANNEL_SELECT[MEAS_EN_LSB +: 3];
  // phase code 3 selects nothing, so the period simply holds
  wire logic per_ok = per_ph != 2'h3 && per_en[per_ph];
  wire logic [2:0] wave_src = I_SAMPLE_SOURCE_SELECT[WAVE_SRC_LSB +: 3];
  wire logic wave_ok = wave_src < 3'(NUM_INPUTS);

  // ---------------------------------------------
  // read selection and snapshot alignment
  // ---------------------------------------------
  wire logic [23:0] rd_val =
    (cmd_addr == ADDR_ACT || cmd_addr == ADDR_ACT_RC) ? act_acc :
    (cmd_addr == ADDR_LACT) ? lact_q :
    (cmd_addr == ADDR_APP || cmd_addr == ADDR_APP_RC) ? app_acc :
    (cmd_addr == ADDR_LAPP) ? lapp_q :
    (cmd_addr == ADDR_PERIOD) ? {9'h000, period_q} :
    (cmd_addr == ADDR_TEMP) ? {16'h0000, temp_q} :
    (cmd_addr == ADDR_WAVE) ? wave_q :
    (cmd_addr == ADDR_OPCFG) ? {16'h0000, cfg_q} :
    24'h000000;
  wire logic [1:0] rd_n = emrm_nbytes(cmd_addr);
  // msb byte of the right-justified value moves to the top of the shifter
  wire logic [23:0] rd_aligned =
    (rd_n == 2'h3) ? rd_val :
    (rd_n == 2'h2) ? {rd_val[15:0], 8'h00} :
    {rd_val[7:0], 16'h0000};

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q <= ST_CMD;
      addr_q <= ADDR_RSVD;
      cnt_q <= 2'h0;
      shift_q <= DATA_RST;
      rd_vld_q <= 1'b0;
      cfg_q <= OPCFG_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (cmd_take) begin
        addr_q <= cmd_addr;
      end
      // whole register frozen here; later updates cannot tear the read
      if (rd_start && !I_ABORT) begin
        shift_q <= rd_aligned;
      end else if (rd_take) begin
        shift_q <= {shift_q[15:0], 8'h00};
      end
      rd_vld_q <= (rd_start || (state_q == ST_RD && !rd_last)) && !I_ABORT;
      if (cfg_wr && !I_ABORT) begin
        cfg_q <= I_RX.data;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      hc_cnt_q <= 16'h0000;
      lact_q <= DATA_RST;
      lapp_q <= DATA_RST;
      period_q <= '0;
      temp_q <= '0;
      wave_q <= '0;
    end else begin
      if (I_HALF_CYC) begin
        hc_cnt_q <= line_done ? 16'h0000 : hc_next[15:0];
      end
      if (line_done) begin
        lact_q <= lact_acc;
        lapp_q <= lapp_acc;
      end
      if (I_PERIOD_STB && per_ok) begin
        period_q <= I_PERIOD[per_ph];
      end
      if (I_TEMP_STB) begin
        temp_q <= I_TEMP;
      end
      if (I_WAVE_STB && wave_ok) begin
        wave_q <= I_WAVE[wave_src];
      end
    end
  end

  assign O_RD_BYTE = shift_q[23:16];
  assign O_RD_VLD = rd_vld_q;
  assign O_OPERATING_CONFIG = cfg_q;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);

  sequence s_rd_cmd(logic [5:0] a);
    state_q == ST_CMD && I_RX.vld && !I_RX.data[CMD_WR_BIT] && cmd_addr == a && !I_ABORT;
  endsequence

  sequence s_one_take;
    I_TX_TAKE && !I_ABORT;
  endsequence

  read_opens_a: assert property (rd_start && !I_ABORT |=> O_RD_VLD && state_q == ST_RD)
    else $error("read command did not open a read phase");
  write_opens_a: assert property (cmd_take && cmd_wr && !I_ABORT |=> state_q == ST_WR && !O_RD_VLD)
    else $error("write command did not open a write phase");
  addr_latch_a: assert property (cmd_take |=> addr_q == $past(I_RX.data[5:0]))
    else $error("address not taken from command bits 5..0");
  snapshot_hold_a: assert property (O_RD_VLD && !I_TX_TAKE && !I_ABORT |=> $stable(O_RD_BYTE))
    else $error("read byte changed without a take");
  act_clear_a: assert property (s_rd_cmd(ADDR_ACT_RC) ##0 !I_PWR_STB |=> act_acc == 24'h000000)
    else $error("active accumulator not cleared by read-clear");
  app_clear_a: assert property (s_rd_cmd(ADDR_APP_RC) ##0 !I_PWR_STB |=> app_acc == 24'h000000)
    else $error("apparent accumulator not cleared by read-clear");
  temp_one_byte_a: assert property (s_rd_cmd(ADDR_TEMP) ##1 s_one_take |=> !O_RD_VLD)
    else $error("temperature read did not end after one byte");
  period_two_byte_a: assert property (s_rd_cmd(ADDR_PERIOD) |=> O_RD_BYTE[7] == 1'b0)
    else $error("period high byte has its spare bit set");
  rsvd_zero_a: assert property (s_rd_cmd(ADDR_RSVD) |=> O_RD_BYTE == 8'h00)
    else $error("reserved address read not zero");
  ro_write_a: assert property (wr_byte && addr_q != ADDR_OPCFG |=> $stable(O_OPERATING_CONFIG))
    else $error("write to read-only address changed config");
  cfg_write_a: assert property (cfg_wr && !I_ABORT |=> O_OPERATING_CONFIG == $past(I_RX.data))
    else $error("config write did not store last byte");
  line_latch_a: assert property (line_done |=> lact_q == $past(lact_acc) && lapp_q == $past(lapp_acc))
    else $error("line cycle energy not latched at count end");

endmodule
`default_nettype wire

// [bench/emrm_host_model.sv]
// partner model: host processor driving the command/data byte port
`timescale 1ns/1ns
`default_nettype none
module emrm_host_model import emrm_pkg::*; (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_byte,
  input wire logic i_rd_vld,
  output var emrm_byte_t o_rx,
  output logic o_take,
  output logic o_abort
);
  // ---------------------------------------------
  // byte level
  // ---------------------------------------------
  initial begin
    o_rx = '{vld: 1'b0, data: 8'h00};
    o_take = 1'b0;
    o_abort = 1'b0;
  end

  function automatic int nb(input logic [5:0] a);
    return (a == 6'h07) ? 2 : ((a == 6'h08 || a == 6'h00 || a >= 6'h0a) ? 1 : 3);
  endfunction

  // idle data shows the inverse so a stale byte never looks fresh
  task automatic put(input logic [7:0] b);
    @(posedge i_clk);
    #1 o_rx = '{vld: 1'b1, data: b};
    @(posedge i_clk);
    #1 o_rx = '{vld: 1'b0, data: ~b};
  endtask

  task automatic pulse(input logic abort);
    @(posedge i_clk);
    #1;
    o_abort = abort;
    o_take = !abort;
    @(posedge i_clk);
    #1;
    o_abort = 1'b0;
    o_take = 1'b0;
  endtask

  // ---------------------------------------------
  // register transfers
  // ---------------------------------------------
  task automatic read_reg(input logic [5:0] a, output logic [23:0] v, output logic ok);
    v = 24'h000000;
    ok = 1'b1;
    put({2'b00, a});
    for (int i = 0; i < nb(a); i++) begin
      ok &= i_rd_vld;
      v = {v[15:0], i_rd_byte};
      pulse(1'b0);
      @(posedge i_clk);
      #1;
    end
    ok &= !i_rd_vld;
  endtask

  task automatic write_reg(input logic [5:0] a, input logic [23:0] v);
    put({2'b10, a});
    for (int i = nb(a) - 1; i >= 0; i--) begin
      put(v[8*i+:8]);
    end
  endtask
endmodule
`default_nettype wire

// [bench/energy_meter_register_map_tb.sv]
// testbench: register map front end driven by a host model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module energy_meter_register_map_tb import emrm_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  emrm_byte_t rx;
  logic take, abort;
  logic [2:0] stb = 3'b000;
  logic [2:0][15:0] act, app;
  logic [15:0] hcc;
  logic [7:0] afs, vfs, mcs, sss, temp;
  logic [2:0][14:0] per;
  logic [5:0][23:0] wave;
  wire logic [7:0] rd_byte;
  wire logic rd_vld;
  wire logic [7:0] opcfg;
  int bad_count = 0;
  int compares = 0;

  always #20 clk = ~clk;

  emrm_host_model host (.i_clk(clk), .i_rd_byte(rd_byte), .i_rd_vld(rd_vld), .o_rx(rx), .o_take(take),
    .o_abort(abort));

  emrm_regmap DUT (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_RX(rx), .I_TX_TAKE(take), .I_ABORT(abort),
    .I_PWR_STB(stb[0]), .I_ACT_PWR(act), .I_APP_PWR(app), .I_HALF_CYC(stb[1]), .I_HALF_CYCLE_COUNT(hcc),
    .I_ACTIVE_FORMULA_SELECT(afs), .I_APPARENT_FORMULA_SELECT(vfs), .I_MEASURE_CHANNEL_SELECT(mcs),
    .I_SAMPLE_SOURCE_SELECT(sss), .I_PERIOD_STB(stb[2]), .I_PERIOD(per), .I_TEMP_STB(stb[2]), .I_TEMP(temp),
    .I_WAVE_STB(stb[2]), .I_WAVE(wave), .O_RD_BYTE(rd_byte), .O_RD_VLD(rd_vld), .O_OPERATING_CONFIG(opcfg));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic strobe(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      #1 stb = m;
      @(posedge clk);
      #1 stb = 3'b000;
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    logic [23:0] v;
    logic ok;
    host.read_reg(a, v, ok);
    `CHK(ok, 1'b1)
    `CHK(v, e)
  endtask

  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset();
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    `CHK(opcfg, 8'h04)
    for (int a = 0; a <= 10; a++) begin
      rd(6'(a), (a == 10) ? 24'h04 : 24'h00);
    end
  endtask

  task automatic t_config();
    host.write_reg(ADDR_OPCFG, 24'h5a);
    @(posedge clk);
    #1;
    `CHK(opcfg, 8'h5a)
    host.write_reg(ADDR_PERIOD, 24'h1234);
    host.write_reg(ADDR_RSVD, 24'hff);
    host.write_reg(6'h3f, 24'hff);
    rd(ADDR_PERIOD, 24'h00);
    rd(ADDR_RSVD, 24'h00);
    rd(6'h3f, 24'h00);
    rd(ADDR_OPCFG, 24'h5a);
  endtask

  task automatic t_energy();
    act = {16'h0003, 16'h0002, 16'h0001};
    app = {16'h0006, 16'h0005, 16'h0004};
    strobe(3'b001, 4);
    rd(ADDR_ACT, 24'h18);
    rd(ADDR_APP, 24'h3c);
    rd(ADDR_ACT_RC, 24'h18);
    rd(ADDR_APP, 24'h3c);
    rd(ADDR_APP_RC, 24'h3c);
    rd(ADDR_ACT, 24'h00);
    rd(ADDR_APP, 24'h00);
    act = {3{16'hffff}};
    strobe(3'b001, 1);
    rd(ADDR_ACT_RC, 24'hfffffd);
    afs = 8'h00;
    vfs = 8'h00;
    strobe(3'b001, 2);
    rd(ADDR_ACT, 24'h00);
    rd(ADDR_APP_RC, 24'h0f);
    afs = 8'h38;
    act = {16'h0003, 16'h0002, 16'h0001};
    strobe(3'b001, 1);
    // an add landing mid-read must not reach the bytes already captured
    fork
      rd(ADDR_ACT, 24'h06);
      begin
        repeat (3) @(posedge clk);
        strobe(3'b001, 1);
      end
    join
    rd(ADDR_ACT_RC, 24'h0c);
    // absolute-value terms: phase b of -2 counts as +2
    afs = 8'h78;
    act = {16'h0003, 16'hfffe, 16'h0001};
    strobe(3'b001, 1);
    rd(ADDR_ACT_RC, 24'h06);
    // negate phase b: 3 - 2 + 1
    afs = 8'hb8;
    act = {16'h0003, 16'h0002, 16'h0001};
    strobe(3'b001, 1);
    rd(ADDR_ACT_RC, 24'h02);
  endtask

  task automatic t_line();
    afs = 8'h3f;
    vfs = 8'h3f;
    hcc = 16'h0002;
    strobe(3'b001, 2);
    strobe(3'b010, 1);
    strobe(3'b001, 1);
    strobe(3'b010, 1);
    rd(ADDR_LACT, 24'h12);
    rd(ADDR_LAPP, 24'h2d);
    strobe(3'b001, 1);
    strobe(3'b010, 2);
    rd(ADDR_LACT, 24'h06);
    rd(ADDR_LAPP, 24'h0f);
  endtask

  task automatic t_aux();
    per = {15'h3333, 15'h2222, 15'h1111};
    temp = 8'ha5;
    mcs = 8'h71;
    strobe(3'b100, 1);
    rd(ADDR_PERIOD, 24'h2222);
    rd(ADDR_TEMP, 24'ha5);
    mcs = 8'h72;
    strobe(3'b100, 1);
    rd(ADDR_PERIOD, 24'h3333);
    mcs = 8'h02;
    per[2] = 15'h7fff;
    strobe(3'b100, 1);
    rd(ADDR_PERIOD, 24'h3333);
    for (int s = 0; s < 6; s++) begin
      sss = 8'(s);
      strobe(3'b100, 1);
      rd(ADDR_WAVE, 24'hc0ffe0 + 24'(s));
    end
    // source 6 and phase code 3 select nothing, so both values hold
    sss = 8'h06;
    mcs = 8'h73;
    strobe(3'b100, 1);
    rd(ADDR_WAVE, 24'hc0ffe5);
    rd(ADDR_PERIOD, 24'h3333);
  endtask

  task automatic t_abort();
    host.put({2'b00, ADDR_TEMP});
    host.put({2'b10, ADDR_OPCFG});
    `CHK(rd_vld, 1'b1)
    `CHK(rd_byte, 8'ha5)
    host.pulse(1'b0);
    `CHK(rd_vld, 1'b0)
    host.put({2'b10, ADDR_OPCFG});
    host.pulse(1'b1);
    host.put({2'b00, ADDR_OPCFG});
    `CHK(rd_byte, 8'h5a)
    host.pulse(1'b0);
    host.put({2'b00, ADDR_ACT});
    host.pulse(1'b1);
    `CHK(rd_vld, 1'b0)
    rd(ADDR_OPCFG, 24'h5a);
  endtask

  // ---------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------
  initial begin
    act = '0;
    app = '0;
    hcc = 16'h0002;
    afs = 8'h38;
    vfs = 8'h38;
    mcs = 8'h71;
    sss = 8'h00;
    per = '0;
    temp = 8'h00;
    for (int i = 0; i < 6; i++) begin
      wave[i] = 24'hc0ffe0 + 24'(i);
    end
    t_reset();
    t_config();
    t_energy();
    t_line();
    t_aux();
    t_abort();
    t_reset();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
